/* File: cell_protection_fsm.sv */
// Protection state machine driving the charge and discharge switch enables of one cell.
// Behaviour
// - No fault: charge and discharge switches both on.
// - Held overvoltage: charge switch off, enter overcharge.
// - Below overcharge release: charge on, back normal.
// - Load diode voltage releases overcharge if cell low.
// - Load with cell still high: stay overcharged.
// - Load with pin below overcurrent: no release.
// - Cell above overcharge: overcurrent detection suppressed.
// - Short detection active in every state except short, overdischarge and overdischarge wake.
// - Held undervoltage: discharge off, enter overdischarge.
// - Overdischarge: pin pulled up, power-down entered.
// - Charger detected leaves power-down, discharge stays off.
// - Cell at overdischarge threshold: discharge on, normal.
// - Weak charger: release at overdischarge release threshold.
// - Held overcurrent: discharge off, enter overcurrent.
// - Overcurrent state pulls pin to ground.
// - Pin below first overcurrent: back to normal.
// - Held charger-detect in normal: charge off.
// - Pin above charger-detect clears abnormal charge.
// - Low cell: no abnormal charge detection.
// - Held short: discharge off, released when pin drops.
// - Zero-volt cell charges through diode, then normal.
// - First attach waits for pin at ground.
// - Overcharge qualification delay is 135 ms.
// - Overdischarge qualification delay is 35 ms.
// - First overcurrent qualification delay is 8 ms.
// - Short qualification delay is 100 us.
`timescale 1ns/1ps
module cell_protection_fsm
    import cellprot_pkg::*;
#(
    parameter logic [TIMER_W-1:0] OVERCHARGE_CYC = OVERCHARGE_QUAL_CYC,
    parameter logic [TIMER_W-1:0] OVERDISCHARGE_CYC = OVERDISCHARGE_QUAL_CYC,
    parameter logic [TIMER_W-1:0] OVERCURRENT1_CYC = FIRST_OVERCURRENT_CYC,
    parameter logic [TIMER_W-1:0] OVERCURRENT2_CYC = SECOND_OVERCURRENT_CYC
)
(
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic CELL_ABOVE_OVERCHARGE_I,
    input wire logic CELL_BELOW_OVERCHARGE_RELEASE_I,
    input wire logic CELL_BELOW_OVERDISCHARGE_I,
    input wire logic CELL_ABOVE_OVERDISCHARGE_RELEASE_I,
    input wire logic PIN_ABOVE_DIODE_I,
    input wire logic PIN_ABOVE_FIRST_OVERCURRENT_I,
    input wire logic PIN_ABOVE_SECOND_OVERCURRENT_I,
    input wire logic PIN_ABOVE_SHORT_I,
    input wire logic PIN_BELOW_CHARGER_DETECT_I,
    input wire logic PIN_AT_GROUND_I,
    output logic CHARGE_EN_O,
    output logic DISCHARGE_EN_O,
    output logic PIN_PULLUP_EN_O,
    output logic PIN_PULLDOWN_EN_O,
    output logic POWER_DOWN_O,
    output logic [STATE_W-1:0] STATE_O
);

    localparam int NSYNC = 10;

    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic cell_hi;
    logic cell_below_rel;
    logic cell_lo;
    logic cell_above_odr;
    logic pin_diode;
    logic pin_oc1;
    logic pin_oc2;
    logic pin_short;
    logic pin_chg;
    logic pin_gnd;
    prot_state_t state_q;
    prot_state_t state_d;
    logic load_seen_q;
    logic oc_tmr_cond;
    logic od_tmr_cond;
    logic oc1_tmr_cond;
    logic oc2_tmr_cond;
    logic short_tmr_cond;
    logic abn_tmr_cond;
    logic oc_done;
    logic od_done;
    logic oc1_done;
    logic oc2_done;
    logic short_done;
    logic abn_done;

    // Comparator outputs are analog and asynchronous, so each passes two flops.
    assign raw_in = {CELL_ABOVE_OVERCHARGE_I, CELL_BELOW_OVERCHARGE_RELEASE_I,
                     CELL_BELOW_OVERDISCHARGE_I, CELL_ABOVE_OVERDISCHARGE_RELEASE_I,
                     PIN_ABOVE_DIODE_I, PIN_ABOVE_FIRST_OVERCURRENT_I,
                     PIN_ABOVE_SECOND_OVERCURRENT_I, PIN_ABOVE_SHORT_I,
                     PIN_BELOW_CHARGER_DETECT_I, PIN_AT_GROUND_I};

    // Two-stage synchroniser for every comparator input.
    always_ff @(posedge MCLK_I)
    begin
        if (!RESETN_I)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    // Synchronised comparator levels.
    assign {cell_hi, cell_below_rel, cell_lo, cell_above_odr, pin_diode, pin_oc1,
            pin_oc2, pin_short, pin_chg, pin_gnd} = sync2_q;

    // Qualifying conditions; every fault timer except the short timer runs only from the normal state.
    assign oc_tmr_cond = (state_q == ST_NORMAL) && cell_hi;
    assign od_tmr_cond = (state_q == ST_NORMAL) && cell_lo;
    assign oc1_tmr_cond = (state_q == ST_NORMAL) && pin_oc1 && !cell_hi;
    assign oc2_tmr_cond = (state_q == ST_NORMAL) && pin_oc2 && !cell_hi;
    assign abn_tmr_cond = (state_q == ST_NORMAL) && pin_chg && !cell_lo;
    // Short watch stays on except in the short state and where discharge is already off with the pin pulled up.
    assign short_tmr_cond = pin_short && (state_q != ST_SHORT) &&
                            (state_q != ST_OVERDISCHARGE) && (state_q != ST_OD_WAKE);

    // Overcharge qualification timer.
    qual_timer #(.LIMIT(OVERCHARGE_CYC)) u_oc_timer (
        .clk_i(MCLK_I),
        .resetn_i(RESETN_I),
        .cond_i(oc_tmr_cond),
        .done_o(oc_done)
    );

    // Overdischarge qualification timer.
    qual_timer #(.LIMIT(OVERDISCHARGE_CYC)) u_od_timer (
        .clk_i(MCLK_I),
        .resetn_i(RESETN_I),
        .cond_i(od_tmr_cond),
        .done_o(od_done)
    );

    // First-level discharge overcurrent timer.
    qual_timer #(.LIMIT(OVERCURRENT1_CYC)) u_oc1_timer (
        .clk_i(MCLK_I),
        .resetn_i(RESETN_I),
        .cond_i(oc1_tmr_cond),
        .done_o(oc1_done)
    );

    // Second-level discharge overcurrent timer with its own shorter delay.
    qual_timer #(.LIMIT(OVERCURRENT2_CYC)) u_oc2_timer (
        .clk_i(MCLK_I),
        .resetn_i(RESETN_I),
        .cond_i(oc2_tmr_cond),
        .done_o(oc2_done)
    );

    // Load short timer.
    qual_timer #(.LIMIT(SHORT_QUAL_CYC)) u_short_timer (
        .clk_i(MCLK_I),
        .resetn_i(RESETN_I),
        .cond_i(short_tmr_cond),
        .done_o(short_done)
    );

    // Abnormal charge current timer, sharing the overcharge delay.
    qual_timer #(.LIMIT(OVERCHARGE_CYC)) u_abn_timer (
        .clk_i(MCLK_I),
        .resetn_i(RESETN_I),
        .cond_i(abn_tmr_cond),
        .done_o(abn_done)
    );

    // Next-state logic; a qualified short outranks every other event.
    always_comb
    begin
        state_d = state_q;
        if (short_done)
            state_d = ST_SHORT;
        else
        begin
            unique case (state_q)
                ST_STARTUP:
                    if (pin_gnd)
                        state_d = ST_NORMAL;
                ST_NORMAL:
                    if (oc_done)
                        state_d = ST_OVERCHARGE;
                    else if (od_done)
                        state_d = ST_OVERDISCHARGE;
                    else if (oc1_done || oc2_done)
                        state_d = ST_OVERCURRENT;
                    else if (abn_done)
                        state_d = ST_ABN_CHARGE;
                ST_OVERCHARGE:
                    if (cell_below_rel)
                        state_d = ST_NORMAL;
                    else if (load_seen_q && !cell_hi && pin_oc1)
                        state_d = ST_NORMAL;
                ST_OVERDISCHARGE:
                    if (cell_above_odr)
                        state_d = ST_NORMAL;
                    else if (pin_chg)
                        state_d = ST_OD_WAKE;
                ST_OD_WAKE:
                    if (!cell_lo)
                        state_d = ST_NORMAL;
                ST_OVERCURRENT:
                    if (!pin_oc1)
                        state_d = ST_NORMAL;
                ST_SHORT:
                    if (!pin_short)
                        state_d = ST_NORMAL;
                ST_ABN_CHARGE:
                    if (!pin_chg)
                        state_d = ST_NORMAL;
            endcase
        end
    end

    // State register; after reset the block waits for the pin to reach ground.
    always_ff @(posedge MCLK_I)
    begin
        if (!RESETN_I)
            state_q <= ST_STARTUP;
        else
            state_q <= state_d;
    end

    // Remembers the diode rise seen on the pin while overcharged, so a load is not missed.
    always_ff @(posedge MCLK_I)
    begin
        if (!RESETN_I)
            load_seen_q <= 1'b0;
        else if (state_q != ST_OVERCHARGE)
            load_seen_q <= 1'b0;
        else if (pin_diode)
            load_seen_q <= 1'b1;
    end

    // Switch enables follow the next state so they change together with it.
    always_ff @(posedge MCLK_I)
    begin
        if (!RESETN_I)
        begin
            CHARGE_EN_O <= 1'b1;
            DISCHARGE_EN_O <= 1'b0;
        end
        else
        begin
            CHARGE_EN_O <= (state_d != ST_OVERCHARGE) &&
                           (state_d != ST_ABN_CHARGE);
            DISCHARGE_EN_O <= (state_d == ST_NORMAL) ||
                              (state_d == ST_OVERCHARGE) || (state_d == ST_ABN_CHARGE);
        end
    end

    // Pin resistors, power-down flag and state code.
    always_ff @(posedge MCLK_I)
    begin
        if (!RESETN_I)
        begin
            PIN_PULLUP_EN_O <= 1'b0;
            PIN_PULLDOWN_EN_O <= 1'b0;
            POWER_DOWN_O <= 1'b0;
            STATE_O <= '0;
        end
        else
        begin
            PIN_PULLUP_EN_O <= (state_d == ST_OVERDISCHARGE) ||
                               (state_d == ST_OD_WAKE);
            PIN_PULLDOWN_EN_O <= (state_d == ST_OVERCURRENT) ||
                                 (state_d == ST_SHORT);
            POWER_DOWN_O <= (state_d == ST_OVERDISCHARGE);
            STATE_O <= state_d;
        end
    end

    // Normal state keeps both switches on.
    a_normal_both_on: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (state_q == ST_NORMAL) |-> (CHARGE_EN_O && DISCHARGE_EN_O))
        else $error("Normal state without both switches on.");

    // A qualified overvoltage moves to overcharge with charge off next cycle.
    a_overcharge_entry: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (state_q == ST_NORMAL && oc_done && !short_done)
        |=> (state_q == ST_OVERCHARGE && !CHARGE_EN_O))
        else $error("Overcharge not entered after qualification.");

    // Cell above overcharge in normal never leads to the overcurrent state.
    a_oc_suppressed: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (state_q == ST_NORMAL && cell_hi) |=> state_q != ST_OVERCURRENT)
        else $error("Overcurrent entered with the cell above overcharge.");

    // Overcharge release by load needs the cell back at or below the threshold.
    a_overcharge_hold: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (state_q == ST_OVERCHARGE && cell_hi && !cell_below_rel && !short_done)
        |=> state_q == ST_OVERCHARGE)
        else $error("Overcharge left while the cell was still high.");

    // A qualified short disables discharge on the next cycle from any state.
    a_short_entry: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        short_done |=> (state_q == ST_SHORT && !DISCHARGE_EN_O && PIN_PULLDOWN_EN_O))
        else $error("Short not acted on.");

    // Overdischarge pulls the pin up and powers down with discharge off.
    a_od_powerdown: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (state_q == ST_OVERDISCHARGE) |-> (PIN_PULLUP_EN_O && POWER_DOWN_O && !DISCHARGE_EN_O))
        else $error("Overdischarge outputs wrong.");

    // Charger detection wakes from power-down but keeps discharge off.
    a_od_wake: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (state_q == ST_OVERDISCHARGE && pin_chg && !cell_above_odr)
        |=> (state_q == ST_OD_WAKE && !POWER_DOWN_O && !DISCHARGE_EN_O))
        else $error("Power-down not released on charger detection.");

    // Overcurrent holds the pin pulldown and ends when the pin falls.
    a_oc_release: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (state_q == ST_OVERCURRENT && !pin_oc1 && !short_done) |=> state_q == ST_NORMAL)
        else $error("Overcurrent not released.");

    // A low cell in normal never leads to the abnormal charge state.
    a_zero_volt_priority: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (state_q == ST_NORMAL && cell_lo) |=> state_q != ST_ABN_CHARGE)
        else $error("Abnormal charge entered with a low cell.");

    // Abnormal charge clears once the pin rises.
    a_abn_release: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (state_q == ST_ABN_CHARGE && !pin_chg && !short_done)
        |=> (state_q == ST_NORMAL && CHARGE_EN_O))
        else $error("Abnormal charge not released.");

    // Main scenarios.
    c_overcharge: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
        state_q == ST_OVERCHARGE ##1 state_q == ST_NORMAL);
    c_od_wake: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
        state_q == ST_OD_WAKE ##1 state_q == ST_NORMAL);
    c_overcurrent: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
        state_q == ST_OVERCURRENT);
    c_short: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
        state_q == ST_SHORT);

endmodule : cell_protection_fsm

/* File: cellprot_pkg.sv */
// Package with states, timing constants and widths for the cell protection state machine.
package cellprot_pkg;

    // System clock rate in kHz, used to turn delays into cycle counts.
    localparam int CLK_KHZ = 40000;
    localparam int CLK_MHZ = 40;

    // Qualification delays in their own units, typical figures.
    localparam int OVERCHARGE_QUAL_DELAY_MS = 135;
    localparam int OVERDISCHARGE_QUAL_DELAY_MS = 35;
    localparam int FIRST_OVERCURRENT_DELAY_MS = 8;
    localparam int SECOND_OVERCURRENT_DELAY_MS = 1;
    localparam int SHORT_QUAL_DELAY_US = 100;

    // Width of every delay counter; holds the longest count.
    localparam int TIMER_W = 23;

    // Cycle counts derived from the delays and the clock rate.
    localparam logic [TIMER_W-1:0] OVERCHARGE_QUAL_CYC =
        TIMER_W'(OVERCHARGE_QUAL_DELAY_MS * CLK_KHZ);
    localparam logic [TIMER_W-1:0] OVERDISCHARGE_QUAL_CYC =
        TIMER_W'(OVERDISCHARGE_QUAL_DELAY_MS * CLK_KHZ);
    localparam logic [TIMER_W-1:0] FIRST_OVERCURRENT_CYC =
        TIMER_W'(FIRST_OVERCURRENT_DELAY_MS * CLK_KHZ);
    localparam logic [TIMER_W-1:0] SECOND_OVERCURRENT_CYC =
        TIMER_W'(SECOND_OVERCURRENT_DELAY_MS * CLK_KHZ);
    localparam logic [TIMER_W-1:0] SHORT_QUAL_CYC =
        TIMER_W'(SHORT_QUAL_DELAY_US * CLK_MHZ);

    // Width of the state code shown on the state output.
    localparam int STATE_W = 3;

    // Protection states.
    typedef enum logic [STATE_W-1:0] {
        ST_STARTUP,
        ST_NORMAL,
        ST_OVERCHARGE,
        ST_OVERDISCHARGE,
        ST_OD_WAKE,
        ST_OVERCURRENT,
        ST_SHORT,
        ST_ABN_CHARGE
    } prot_state_t;

endpackage : cellprot_pkg

/* File: qual_timer.sv */
// Qualification timer that flags a condition held continuously for a set number of cycles.
`timescale 1ns/1ps
module qual_timer
    import cellprot_pkg::*;
#(
    parameter logic [TIMER_W-1:0] LIMIT = 23'h000010
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic cond_i,
    output logic done_o
);

    logic [TIMER_W-1:0] cnt_q;

    // Counts while the condition holds, saturates at the limit, restarts when it drops.
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            cnt_q <= '0;
        else if (!cond_i)
            cnt_q <= '0;
        else if (cnt_q != LIMIT)
            cnt_q <= cnt_q + TIMER_W'(1);
    end

    // The condition has been held for the full limit.
    assign done_o = cond_i && (cnt_q == LIMIT);

    // A dropped condition clears the count.
    a_timer_restart: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !cond_i |=> cnt_q == '0)
        else $error("Timer did not restart after the condition dropped.");

    // The count never passes the limit.
    a_timer_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
        cnt_q <= LIMIT)
        else $error("Timer count passed its limit.");

endmodule : qual_timer

/* File: cell_pack_model.sv */
// Behavioural model of the cell, charger and load as seen through the comparators.
`timescale 1ns/1ps
module cell_pack_model #(
    parameter int OVERCHARGE_MV = 4300,
    parameter int OVERCHARGE_RELEASE_MV = 4100,
    parameter int OVERDISCHARGE_MV = 2400,
    parameter int OVERDISCHARGE_RELEASE_MV = 3000,
    parameter int CHARGER_DETECT_MV = -120,
    parameter int DIODE_MV = 500,
    parameter int FIRST_OC_MV = 100,
    parameter int SECOND_OC_MV = 175,
    parameter int SHORT_MV = 1000,
    parameter int GROUND_MV = 10
)
(
    input wire logic signed [15:0] cell_mv_i,
    input wire logic signed [15:0] pin_mv_i,
    input wire logic pin_float_i,
    input wire logic pullup_en_i,
    input wire logic pulldown_en_i,
    output logic above_overcharge_o,
    output logic below_overcharge_release_o,
    output logic below_overdischarge_o,
    output logic above_overdischarge_release_o,
    output logic pin_above_diode_o,
    output logic pin_above_first_oc_o,
    output logic pin_above_second_oc_o,
    output logic pin_above_short_o,
    output logic pin_below_charger_o,
    output logic pin_at_ground_o
);
    logic signed [15:0] pin;

    // A floating pin follows the internal pull-up to the cell, otherwise it leaks to ground.
    assign pin = pin_float_i ? ((pullup_en_i && !pulldown_en_i) ? cell_mv_i : 16'sh0000)
                             : pin_mv_i;

    // Comparator levels derived from the analog values.
    assign above_overcharge_o = cell_mv_i > OVERCHARGE_MV;
    assign below_overcharge_release_o = cell_mv_i < OVERCHARGE_RELEASE_MV;
    assign below_overdischarge_o = cell_mv_i < OVERDISCHARGE_MV;
    assign above_overdischarge_release_o = cell_mv_i >= OVERDISCHARGE_RELEASE_MV;
    assign pin_above_diode_o = pin >= DIODE_MV;
    assign pin_above_first_oc_o = pin >= FIRST_OC_MV;
    assign pin_above_second_oc_o = pin >= SECOND_OC_MV;
    assign pin_above_short_o = pin > SHORT_MV;
    assign pin_below_charger_o = pin < CHARGER_DETECT_MV;
    assign pin_at_ground_o = (pin <= GROUND_MV) && (pin >= -GROUND_MV);
endmodule : cell_pack_model

/* File: tb_cell_protection_fsm.sv */
// Self-checking testbench for the cell protection state machine.
`timescale 1ns/1ps
module tb_cell_protection_fsm;
    import cellprot_pkg::*;
    localparam int OC_LIM = 40;
    localparam int OD_LIM = 30;
    localparam int I1_LIM = 20;
    localparam int I2_LIM = 10;
    localparam int SH_LIM = 4000;

    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic signed [15:0] cell_mv = 16'sh0F3C;
    logic signed [15:0] pin_mv = 16'sh012C;
    logic pin_float = 1'b0;
    logic c_ovc, c_ovc_rel, c_odc, c_odc_rel, p_diode, p_oc1, p_oc2, p_short, p_chg, p_gnd;
    logic chg_en, dis_en, pu_en, pd_en, pwr_dn;
    logic [STATE_W-1:0] state;
    int error_cnt = 0;
    int checks = 0;

    // Free-running 40 MHz clock.
    always #12.5 mclk = ~mclk;

    cell_protection_fsm #(
        .OVERCHARGE_CYC(TIMER_W'(OC_LIM)),
        .OVERDISCHARGE_CYC(TIMER_W'(OD_LIM)),
        .OVERCURRENT1_CYC(TIMER_W'(I1_LIM)),
        .OVERCURRENT2_CYC(TIMER_W'(I2_LIM))
    ) cell_protection_fsm_i (
        .MCLK_I(mclk), .RESETN_I(resetn),
        .CELL_ABOVE_OVERCHARGE_I(c_ovc), .CELL_BELOW_OVERCHARGE_RELEASE_I(c_ovc_rel),
        .CELL_BELOW_OVERDISCHARGE_I(c_odc), .CELL_ABOVE_OVERDISCHARGE_RELEASE_I(c_odc_rel),
        .PIN_ABOVE_DIODE_I(p_diode), .PIN_ABOVE_FIRST_OVERCURRENT_I(p_oc1),
        .PIN_ABOVE_SECOND_OVERCURRENT_I(p_oc2), .PIN_ABOVE_SHORT_I(p_short),
        .PIN_BELOW_CHARGER_DETECT_I(p_chg), .PIN_AT_GROUND_I(p_gnd),
        .CHARGE_EN_O(chg_en), .DISCHARGE_EN_O(dis_en), .PIN_PULLUP_EN_O(pu_en),
        .PIN_PULLDOWN_EN_O(pd_en), .POWER_DOWN_O(pwr_dn), .STATE_O(state)
    );

    cell_pack_model cell_pack_model_i (
        .cell_mv_i(cell_mv), .pin_mv_i(pin_mv), .pin_float_i(pin_float),
        .pullup_en_i(pu_en), .pulldown_en_i(pd_en),
        .above_overcharge_o(c_ovc), .below_overcharge_release_o(c_ovc_rel),
        .below_overdischarge_o(c_odc), .above_overdischarge_release_o(c_odc_rel),
        .pin_above_diode_o(p_diode), .pin_above_first_oc_o(p_oc1),
        .pin_above_second_oc_o(p_oc2), .pin_above_short_o(p_short),
        .pin_below_charger_o(p_chg), .pin_at_ground_o(p_gnd)
    );

    // Counts one comparison and reports a mismatch.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Applies a new cell and pin condition just after a rising edge.
    task automatic drive(input int c, input int p, input logic f);
        @(posedge mclk);
        cell_mv <= 16'(c);
        pin_mv <= 16'(p);
        pin_float <= f;
    endtask : drive

    // Mask and levels of {charge, discharge, pull-up, pull-down, power-down} per state.
    function automatic logic [9:0] outs(input prot_state_t s);
        case (s)
            ST_STARTUP: return 10'h3F0;
            ST_NORMAL: return 10'h3F8;
            ST_OVERCHARGE: return 10'h328;
            ST_OVERDISCHARGE: return 10'h3F5;
            ST_OD_WAKE: return 10'h330;
            ST_OVERCURRENT: return 10'h1E2;
            ST_SHORT: return 10'h162;
            default: return 10'h3E8;
        endcase
    endfunction : outs

    // Waits a bounded time for a state, then checks entry time and output levels.
    task automatic wait_st(input prot_state_t s, input int lo, input int hi);
        int n;
        logic [9:0] e;
        n = 0;
        e = outs(s);
        while (state !== s && n <= hi)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(16'(state), 16'(s));
        if (n < lo || n > hi)
            chk(16'(n), 16'(lo));
        chk(16'(e[9:5] & {chg_en, dis_en, pu_en, pd_en, pwr_dn}), 16'(e[9:5] & e[4:0]));
    endtask : wait_st

    // Checks that the state holds for a number of cycles.
    task automatic stay(input prot_state_t s, input int n);
        repeat (n)
        begin
            @(posedge mclk);
            #1;
            if (state !== s)
                break;
        end
        chk(16'(state), 16'(s));
    endtask : stay

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    // Main sequence of scenarios.
    initial
    begin
        void'($urandom(45839));
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        wait_st(ST_STARTUP, 0, 0);
        stay(ST_STARTUP, 10);
        drive(3900, 0, 1'b0);
        wait_st(ST_NORMAL, 0, 6);
        // High cell with a pin above both overcurrent levels: overcurrent must stay quiet.
        drive(4400, 200, 1'b0);
        stay(ST_NORMAL, 20);
        drive(4000, 0, 1'b0);
        drive(4400, 0, 1'b0);
        wait_st(ST_OVERCHARGE, OC_LIM, OC_LIM + 8);
        drive(4400, 800, 1'b0);
        stay(ST_OVERCHARGE, 30);
        drive(4200, 50, 1'b0);
        stay(ST_OVERCHARGE, 30);
        drive(4200, 800, 1'b0);
        wait_st(ST_NORMAL, 0, 6);
        wait_st(ST_OVERCURRENT, I2_LIM - 2, I2_LIM + 8);
        drive(4000, 0, 1'b1);
        wait_st(ST_NORMAL, 0, 6);
        drive(4000, 150, 1'b0);
        wait_st(ST_OVERCURRENT, I1_LIM, I1_LIM + 8);
        drive(4000, 0, 1'b1);
        wait_st(ST_NORMAL, 0, 6);
        // Random low-cell dips that end before the qualification delay.
        repeat (8)
        begin
            drive(2000, 0, 1'b0);
            stay(ST_NORMAL, $urandom_range(25, 5));
            drive($urandom_range(4200, 2500), $urandom_range(90, 0), 1'b0);
            stay(ST_NORMAL, 3);
        end
        drive(0, 0, 1'b1);
        wait_st(ST_OVERDISCHARGE, OD_LIM, OD_LIM + 8);
        drive(0, -200, 1'b0);
        wait_st(ST_OD_WAKE, 0, 6);
        stay(ST_OD_WAKE, 60);
        drive(2600, -200, 1'b0);
        wait_st(ST_NORMAL, 0, 6);
        wait_st(ST_ABN_CHARGE, OC_LIM - 2, OC_LIM + 8);
        drive(2600, 0, 1'b0);
        wait_st(ST_NORMAL, 0, 6);
        drive(2000, 0, 1'b1);
        wait_st(ST_OVERDISCHARGE, OD_LIM, OD_LIM + 8);
        drive(2600, 0, 1'b1);
        stay(ST_OVERDISCHARGE, 20);
        drive(3100, 0, 1'b1);
        wait_st(ST_NORMAL, 0, 6);
        drive(4400, 0, 1'b0);
        wait_st(ST_OVERCHARGE, OC_LIM, OC_LIM + 8);
        drive(4000, 0, 1'b0);
        wait_st(ST_NORMAL, 0, 6);
        drive(4400, 0, 1'b0);
        wait_st(ST_OVERCHARGE, OC_LIM, OC_LIM + 8);
        drive(4400, 1500, 1'b0);
        wait_st(ST_SHORT, SH_LIM, SH_LIM + 10);
        drive(4000, 0, 1'b1);
        wait_st(ST_NORMAL, 0, 60);
        results();
    end

    // Watchdog that cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        results();
    end
endmodule : tb_cell_protection_fsm
